// ==== ssp_fifo.sv ====
`timescale 1ns/10ps
module ssp_fifo (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  ssp_fifo_if.fifo f
);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  logic [ssp_pkg::WORD_W-1:0] mem_r [ssp_pkg::FIFO_DEPTH];
  logic [ssp_pkg::FIFO_AW-1:0] wr_ptr_r;
  logic [ssp_pkg::FIFO_AW-1:0] rd_ptr_r;
  logic [3:0] cnt_r;
  logic do_wr;
  logic do_rd;

  // handshakes and status straight from the count
  assign f.empty = (cnt_r == ssp_pkg::CNT_RST);
  assign f.full = (cnt_r == ssp_pkg::FIFO_CNT_FULL);
  assign f.wr_ready = !f.full;
  assign f.rd_valid = !f.empty;
  assign f.rd_data = mem_r[rd_ptr_r];
  assign do_wr = f.wr_valid && !f.full;
  assign do_rd = f.rd_ready && !f.empty;

  // write side, storage has no reset
  always_ff @(posedge i_clk_sys) begin
    if (do_wr) begin
      mem_r[wr_ptr_r] <= f.wr_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr_r <= ssp_pkg::PTR_RST;
      rd_ptr_r <= ssp_pkg::PTR_RST;
      cnt_r <= ssp_pkg::CNT_RST;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 3'h1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 3'h1;
      end
      if (do_wr && !do_rd) begin
        cnt_r <= cnt_r + 4'h1;
      end else if (do_rd && !do_wr) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end

endmodule // ssp_fifo

// ==== ssp_fifo_if.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------------
// word stream into and out of one buffer
// ------------------------------------------------------------------
interface ssp_fifo_if;
  logic wr_valid;
  logic wr_ready;
  logic [ssp_pkg::WORD_W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [ssp_pkg::WORD_W-1:0] rd_data;
  logic empty;
  logic full;

  modport fifo (
    input wr_valid,
    input wr_data,
    input rd_ready,
    output wr_ready,
    output rd_valid,
    output rd_data,
    output empty,
    output full
  );

  modport user (
    output wr_valid,
    output wr_data,
    output rd_ready,
    input wr_ready,
    input rd_valid,
    input rd_data,
    input empty,
    input full
  );
endinterface

// ==== ssp_periph_model.sv ====
`timescale 1ns/10ps
module ssp_periph_model (
  input wire logic i_sclk,
  input wire logic i_fss,
  input wire logic i_mosi,
  input wire logic i_pha,
  input wire logic i_fss_low,
  input wire logic [4:0] i_bits,
  input wire logic [15:0] i_reply,
  output logic o_miso,
  output logic [15:0] o_got
);
  logic [15:0] sh_r = 16'h0000;
  int cnt = 0;
  initial o_miso = 1'b1;
  initial o_got = 16'h0000;
  // ----------------------------------------------------------------
  // frame start: load reply left-aligned, present its top bit
  // ----------------------------------------------------------------
  always @(i_fss) begin
    if (i_fss === !i_fss_low) begin
      sh_r = i_reply << (16 - i_bits);
      cnt = 0;
      o_got = 16'h0000;
      o_miso = sh_r[15];
    end
  end
  // sample edge: take one bit, invert the line after the last one
  always @(posedge i_sclk or negedge i_sclk) begin
    if (i_sclk === !i_pha) begin
      o_got = {o_got[14:0], i_mosi};
      cnt++;
      if (cnt == i_bits) o_miso = ~o_miso;
    end else if (cnt > 0 && cnt < i_bits) begin
      sh_r = sh_r << 1;
      o_miso = sh_r[15];
    end
  end
endmodule // ssp_periph_model

// ==== ssp_pkg.sv ====
package ssp_pkg;

  // ----------------------------------------------------------------
  // word and buffer geometry
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  localparam logic [3:0] FIFO_CNT_FULL = 4'h8;

  // ----------------------------------------------------------------
  // frame size: code is bits minus one, 4 to 16 bits
  // ----------------------------------------------------------------
  localparam logic [3:0] SIZE_MIN = 4'h3;
  localparam logic [3:0] SIZE_MAX = 4'hf;

  // ----------------------------------------------------------------
  // frame formats
  // ----------------------------------------------------------------
  localparam logic [1:0] FMT_SPI = 2'h0;
  localparam logic [1:0] FMT_PULSE = 2'h1;
  localparam logic [1:0] FMT_GATED = 2'h2;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] PRE_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [4:0] EDGE_RST = 5'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [2:0] PTR_RST = 3'h0;

  // ----------------------------------------------------------------
  // transfer engine states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_XFER,
    ST_GAP
  } ssp_state_t;

endpackage

// ==== ssp_port_chk.sv ====
`timescale 1ns/10ps
module ssp_port_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_master,
  input wire logic i_slave_out_off,
  input wire logic [1:0] i_frame_fmt,
  input wire logic i_clk_pol,
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic o_rx_valid,
  input wire logic o_tx_empty,
  input wire logic o_tx_not_full,
  input wire logic o_rx_not_empty,
  input wire logic o_rx_full,
  input wire logic o_busy,
  input wire logic o_sclk_o,
  input wire logic o_sclk_oe,
  input wire logic o_fss_o,
  input wire logic o_fss_oe,
  input wire logic o_txd_oe
);
  // ----------------------------------------------------------------
  // port behaviour
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  a_reset_quiet: assert property (disable iff (1'b0) i_rst |->
    !o_sclk_oe && !o_fss_oe && !o_txd_oe && !o_busy && o_tx_empty)
    else $error("pins or flags active in reset");
  a_master_drives: assert property (i_enable && i_master |-> o_sclk_oe && o_fss_oe)
    else $error("master not driving clock and frame");
  a_slave_release: assert property (!i_master && i_slave_out_off |-> !o_txd_oe)
    else $error("released slave drives data");
  a_idle_disabled: assert property (!i_enable |-> !o_sclk_oe && !o_txd_oe && !o_fss_oe)
    else $error("disabled port drives a pin");
  a_flag_match: assert property (o_tx_ready == o_tx_not_full && o_rx_valid == o_rx_not_empty)
    else $error("handshake and status disagree");
  a_write_taken: assert property (i_tx_valid && o_tx_ready |=> !o_tx_empty && o_busy)
    else $error("accepted word not seen");
  a_busy_hold: assert property ($fell(o_tx_empty) |-> o_busy [*3])
    else $error("busy dropped early");
  a_sclk_idle: assert property (i_enable && i_master && !i_clk_pol && !o_busy |-> !o_sclk_o)
    else $error("serial clock not idle");
  a_frame_idle: assert property (i_enable && i_master && !o_busy |->
    o_fss_o == (i_frame_fmt == ssp_pkg::FMT_SPI))
    else $error("frame signal not idle");

  c_refused: cover property (i_tx_valid && !o_tx_ready);
  c_rx_full: cover property (o_rx_full);
  c_slave_out: cover property (!i_master && o_txd_oe);
endmodule // ssp_port_chk

bind ssp_sync_serial_port ssp_port_chk u_chk (.*);

// ==== ssp_sync_serial_port.sv ====
`timescale 1ns/10ps
module ssp_sync_serial_port (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire logic i_master,
  input wire logic i_slave_out_off,
  input wire logic [1:0] i_frame_fmt,
  input wire logic [3:0] i_size,
  input wire logic i_clk_pol,
  input wire logic i_clk_pha,
  input wire logic [7:0] i_prescale,
  input wire logic [7:0] i_rate,
  input wire logic i_tx_valid,
  input wire logic [15:0] i_tx_data,
  output logic o_tx_ready,
  output logic o_rx_valid,
  output logic [15:0] o_rx_data,
  input wire logic i_rx_ready,
  output logic o_tx_empty,
  output logic o_tx_not_full,
  output logic o_rx_not_empty,
  output logic o_rx_full,
  output logic o_busy,
  output logic o_sclk_o,
  output logic o_sclk_oe,
  input wire logic i_sclk_i,
  output logic o_fss_o,
  output logic o_fss_oe,
  input wire logic i_fss_i,
  output logic o_txd_o,
  output logic o_txd_oe,
  input wire logic i_rxd
);

  // ----------------------------------------------------------------
  // buffers
  // ----------------------------------------------------------------
  ssp_fifo_if tx_if ();
  ssp_fifo_if rx_if ();

  ssp_fifo u_tx_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .f(tx_if.fifo)
  );

  ssp_fifo u_rx_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .f(rx_if.fifo)
  );

  logic [15:0] rx_word;
  logic [15:0] size_mask;
  logic frame_done;
  logic load_ev;

  // processor and engine sides of the buffers
  assign tx_if.wr_valid = i_tx_valid;
  assign tx_if.wr_data = i_tx_data;
  assign o_tx_ready = tx_if.wr_ready;
  assign rx_if.rd_ready = i_rx_ready;
  assign o_rx_valid = rx_if.rd_valid;
  assign o_rx_data = rx_if.rd_data;
  assign tx_if.rd_ready = load_ev;
  assign rx_if.wr_valid = frame_done;
  assign rx_if.wr_data = rx_word & size_mask;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_s1_r;
  logic sclk_s2_r;
  logic sclk_s3_r;
  logic fss_s1_r;
  logic fss_s2_r;
  logic fss_s3_r;
  logic rxd_s1_r;
  logic rxd_s2_r;

  // two flops on each pin, a third only for edge finding
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_s3_r <= 1'b0;
      fss_s1_r <= 1'b0;
      fss_s2_r <= 1'b0;
      fss_s3_r <= 1'b0;
      rxd_s1_r <= 1'b0;
      rxd_s2_r <= 1'b0;
    end else begin
      sclk_s1_r <= i_sclk_i;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      fss_s1_r <= i_fss_i;
      fss_s2_r <= fss_s1_r;
      fss_s3_r <= fss_s2_r;
      rxd_s1_r <= i_rxd;
      rxd_s2_r <= rxd_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // frame settings
  // ----------------------------------------------------------------
  logic [3:0] size_c;
  logic is_spi;
  logic late_pha;
  logic idle_pol;
  logic [4:0] last_edge;

  assign size_c = (i_size < ssp_pkg::SIZE_MIN) ? ssp_pkg::SIZE_MIN : i_size;
  assign is_spi = (i_frame_fmt == ssp_pkg::FMT_SPI);
  assign late_pha = is_spi ? i_clk_pha : 1'b1;
  assign idle_pol = is_spi ? i_clk_pol : 1'b0;
  assign last_edge = {size_c, 1'b1};

  // keep only the bits of the chosen frame length
  for (genvar b = 0; b < ssp_pkg::WORD_W; b++) begin : g_mask
    assign size_mask[b] = (4'(b) <= size_c);
  end

  // ----------------------------------------------------------------
  // master clock divider
  // ----------------------------------------------------------------
  logic [7:0] pre_cnt_r;
  logic [7:0] rate_cnt_r;
  logic [7:0] pre_half;
  logic pre_tick;
  logic half_ev;
  ssp_pkg::ssp_state_t state_r;

  // half bit = (prescale/2) * (rate+1) clocks, prescale at least 2
  assign pre_half = (i_prescale[7:1] == 7'h00) ? 8'h01 : {1'b0, i_prescale[7:1]};
  assign pre_tick = (pre_cnt_r == pre_half - 8'h01);
  assign half_ev = pre_tick && (rate_cnt_r == i_rate);

  // prescaler then rate divider, held at zero while idle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pre_cnt_r <= ssp_pkg::PRE_RST;
      rate_cnt_r <= ssp_pkg::RATE_RST;
    end else if (state_r == ssp_pkg::ST_IDLE) begin
      pre_cnt_r <= ssp_pkg::PRE_RST;
      rate_cnt_r <= ssp_pkg::RATE_RST;
    end else if (pre_tick) begin
      pre_cnt_r <= ssp_pkg::PRE_RST;
      rate_cnt_r <= half_ev ? ssp_pkg::RATE_RST : rate_cnt_r + 8'h01;
    end else begin
      pre_cnt_r <= pre_cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // edge events of the serial clock
  // ----------------------------------------------------------------
  logic [4:0] edge_r;
  logic edge_ev;
  logic lead_ev;
  logic trail_ev;
  logic shift_ev;
  logic capt_ev;
  logic slv_start;
  logic slv_abort;
  logic run;

  localparam logic [4:0] EDGE_ZERO = ssp_pkg::EDGE_RST;

  assign run = i_enable;
  // master: divider; slave: any synced clock change
  assign edge_ev = (state_r == ssp_pkg::ST_XFER) &&
                   (i_master ? half_ev : (sclk_s2_r != sclk_s3_r));
  assign lead_ev = edge_ev && !edge_r[0];
  assign trail_ev = edge_ev && edge_r[0];
  assign shift_ev = late_pha ? (lead_ev && (edge_r != EDGE_ZERO)) : trail_ev;
  assign capt_ev = late_pha ? trail_ev : lead_ev;
  assign frame_done = edge_ev && (edge_r == last_edge);

  // slave frame start and early end by the frame signal
  always_comb begin
    slv_start = 1'b0;
    slv_abort = 1'b0;
    if (i_frame_fmt == ssp_pkg::FMT_SPI) begin
      slv_start = !fss_s2_r;
      slv_abort = fss_s2_r;
    end else if (i_frame_fmt == ssp_pkg::FMT_PULSE) begin
      slv_start = fss_s2_r && !fss_s3_r;
    end else begin
      slv_start = fss_s2_r;
      slv_abort = !fss_s2_r;
    end
  end

  // ----------------------------------------------------------------
  // transfer state machine
  // ----------------------------------------------------------------
  ssp_pkg::ssp_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    load_ev = 1'b0;
    case (state_r)
      ssp_pkg::ST_IDLE: begin
        if (run && i_master && tx_if.rd_valid) begin
          state_nxt = ssp_pkg::ST_SETUP;
          load_ev = 1'b1;
        end else if (run && !i_master && slv_start) begin
          state_nxt = ssp_pkg::ST_XFER;
          load_ev = tx_if.rd_valid;
        end
      end
      ssp_pkg::ST_SETUP: begin
        if (half_ev) begin
          state_nxt = ssp_pkg::ST_XFER;
        end
      end
      ssp_pkg::ST_XFER: begin
        if (!i_master && slv_abort) begin
          state_nxt = ssp_pkg::ST_IDLE;
        end else if (frame_done) begin
          state_nxt = i_master ? ssp_pkg::ST_GAP : ssp_pkg::ST_IDLE;
        end
      end
      default: begin
        if (half_ev) begin
          state_nxt = ssp_pkg::ST_IDLE;
        end
      end
    endcase
    if (!run) begin
      state_nxt = ssp_pkg::ST_IDLE;
    end
  end

  // state and edge count
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ssp_pkg::ST_IDLE;
      edge_r <= ssp_pkg::EDGE_RST;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != ssp_pkg::ST_XFER) begin
        edge_r <= ssp_pkg::EDGE_RST;
      end else if (edge_ev) begin
        edge_r <= edge_r + 5'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // shift registers
  // ----------------------------------------------------------------
  logic [15:0] tx_sh_r;
  logic [15:0] rx_sh_r;

  // word is left aligned so the next bit is always the top one
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_sh_r <= ssp_pkg::WORD_RST;
    end else if (state_r == ssp_pkg::ST_IDLE && state_nxt != ssp_pkg::ST_IDLE) begin
      tx_sh_r <= load_ev ? (tx_if.rd_data << (ssp_pkg::SIZE_MAX - size_c))
                         : ssp_pkg::WORD_RST;
    end else if (shift_ev) begin
      tx_sh_r <= {tx_sh_r[14:0], 1'b0};
    end else if (state_nxt == ssp_pkg::ST_IDLE) begin
      tx_sh_r <= ssp_pkg::WORD_RST;
    end
  end

  // last sample may land on the final edge itself
  assign rx_word = capt_ev ? {rx_sh_r[14:0], rxd_s2_r} : rx_sh_r;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_sh_r <= ssp_pkg::WORD_RST;
    end else if (state_r == ssp_pkg::ST_IDLE) begin
      rx_sh_r <= ssp_pkg::WORD_RST;
    end else if (capt_ev) begin
      rx_sh_r <= {rx_sh_r[14:0], rxd_s2_r};
    end
  end

  // ----------------------------------------------------------------
  // serial clock out
  // ----------------------------------------------------------------
  logic sclk_r;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      sclk_r <= 1'b0;
    end else if (state_r != ssp_pkg::ST_XFER) begin
      sclk_r <= idle_pol;
    end else if (edge_ev) begin
      sclk_r <= !sclk_r;
    end
  end

  // ----------------------------------------------------------------
  // pins and status
  // ----------------------------------------------------------------
  logic in_frame;

  assign in_frame = (state_r == ssp_pkg::ST_SETUP) || (state_r == ssp_pkg::ST_XFER);

  // frame signal: low in SPI, one setup pulse, or high for the frame
  always_comb begin
    if (i_frame_fmt == ssp_pkg::FMT_SPI) begin
      o_fss_o = !in_frame;
    end else if (i_frame_fmt == ssp_pkg::FMT_PULSE) begin
      o_fss_o = (state_r == ssp_pkg::ST_SETUP);
    end else begin
      o_fss_o = in_frame;
    end
  end

  assign o_sclk_o = sclk_r;
  assign o_txd_o = tx_sh_r[15];
  assign o_sclk_oe = run && i_master;
  assign o_fss_oe = run && i_master;
  assign o_txd_oe = run && (i_master ||
                    ((state_r == ssp_pkg::ST_XFER) && !i_slave_out_off));
  assign o_tx_empty = tx_if.empty;
  assign o_tx_not_full = !tx_if.full;
  assign o_rx_not_empty = !rx_if.empty;
  assign o_rx_full = rx_if.full;
  assign o_busy = (state_r != ssp_pkg::ST_IDLE) || !tx_if.empty;

endmodule // ssp_sync_serial_port

// ==== tb_sync_serial_port.sv ====
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_sync_serial_port;
  typedef struct packed {
    logic [1:0] fmt; logic [3:0] size; logic pha; logic [7:0] pre;
    logic [7:0] rate; logic [15:0] tx; logic [15:0] rep; logic [7:0] h;
  } ssp_row_t;
  logic i_clk_sys = 0, i_rst = 0, i_enable = 0, i_master = 1, i_slave_out_off = 0;
  logic [1:0] i_frame_fmt = 0;
  logic [3:0] i_size = 4'hf;
  logic i_clk_pol = 0, i_clk_pha = 0, i_tx_valid = 0, i_rx_ready = 0;
  logic [7:0] i_prescale = 8'h02, i_rate = 8'h02;
  logic [15:0] i_tx_data = 0, o_rx_data, reply = 0, got;
  logic o_tx_ready, o_rx_valid, o_tx_empty, o_tx_not_full, o_rx_not_empty, o_rx_full;
  logic o_busy, o_sclk_o, o_sclk_oe, o_fss_o, o_fss_oe, o_txd_o, o_txd_oe, i_rxd;
  logic i_sclk_i = 0, i_fss_i = 1, rxd_tb = 1, miso;
  logic [4:0] nbits;
  logic [7:0] hc, sgot;
  int fails = 0, samples_checked = 0;
  // rows run slow enough for the peripheral
  ssp_row_t rows [5] = '{
    '{2'h0, 4'hf, 1'h0, 8'h02, 8'h02, 16'hc3a5, 16'h5a3c, 8'h03},
    '{2'h0, 4'h3, 1'h1, 8'h04, 8'h01, 16'h000b, 16'h0006, 8'h04},
    '{2'h1, 4'h7, 1'h0, 8'h06, 8'h00, 16'h0096, 16'h0069, 8'h03},
    '{2'h2, 4'hb, 1'h0, 8'h03, 8'h02, 16'h0a5c, 16'h05a3, 8'h03},
    '{2'h0, 4'h2, 1'h0, 8'h01, 8'h03, 16'h0009, 16'h0006, 8'h04}};

  always #20 i_clk_sys = ~i_clk_sys;
  // sizes below four bits clamp to four
  assign nbits = (i_size < 4'h3) ? 5'h04 : {1'b0, i_size} + 5'h01;
  assign i_rxd = i_master ? miso : rxd_tb;

  ssp_sync_serial_port u_dut (.*);
  ssp_periph_model u_peer (.i_sclk(o_sclk_o), .i_fss(o_fss_o), .i_mosi(o_txd_o),
    .i_pha(i_clk_pha | (i_frame_fmt != ssp_pkg::FMT_SPI)),
    .i_fss_low(i_frame_fmt == ssp_pkg::FMT_SPI), .i_bits(nbits), .i_reply(reply),
    .o_miso(miso), .o_got(got));

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic push(input logic [15:0] w);
    @(posedge i_clk_sys);
    i_tx_valid <= 1'b1;
    i_tx_data <= w;
    @(posedge i_clk_sys);
    i_tx_valid <= 1'b0;
  endtask
  task automatic pop();
    @(posedge i_clk_sys);
    i_rx_ready <= 1'b1;
    @(posedge i_clk_sys);
    i_rx_ready <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (o_busy !== 1'b0 && n < 5000) begin
      @(negedge i_clk_sys);
      n++;
    end
    // a port that never goes idle counts as a mismatch
    if (o_busy !== 1'b0) fails++;
  endtask
  // one master frame; returns cycles of the first clock high phase
  task automatic xfer(input logic [15:0] w);
    int n;
    n = 0;
    hc = 8'h00;
    push(w);
    while (o_sclk_o !== 1'b1 && n < 500) begin
      @(negedge i_clk_sys);
      n++;
    end
    // no serial clock at all counts as a mismatch
    if (o_sclk_o !== 1'b1) fails++;
    while (o_sclk_o === 1'b1 && hc < 8'hff) begin
      @(negedge i_clk_sys);
      hc++;
    end
    wait_idle();
  endtask
  // slave frame, mode 0, eight bits, eight cycles per half bit
  task automatic sframe(input logic [7:0] w);
    @(posedge i_clk_sys);
    i_fss_i <= 1'b0;
    repeat (8) @(posedge i_clk_sys);
    `CHK(o_txd_oe, !i_slave_out_off);
    for (int i = 7; i >= 0; i--) begin
      rxd_tb <= w[i];
      repeat (8) @(posedge i_clk_sys);
      sgot[i] = o_txd_o;
      i_sclk_i <= 1'b1;
      repeat (8) @(posedge i_clk_sys);
      i_sclk_i <= 1'b0;
    end
    repeat (8) @(posedge i_clk_sys);
    i_fss_i <= 1'b1;
    rxd_tb <= ~w[0];
    repeat (8) @(negedge i_clk_sys);
    `CHK(o_rx_data, {8'h00, w});
    pop();
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_rst <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(negedge i_clk_sys);
    `CHK({o_tx_empty, o_rx_not_empty, o_busy, o_txd_oe}, 4'h8);
    @(posedge i_clk_sys);
    i_enable <= 1'b1;
    foreach (rows[k]) begin
      @(posedge i_clk_sys);
      {i_frame_fmt, i_size, i_clk_pha} <= {rows[k].fmt, rows[k].size, rows[k].pha};
      {i_prescale, i_rate, reply} <= {rows[k].pre, rows[k].rate, rows[k].rep};
      @(posedge i_clk_sys);
      xfer(rows[k].tx);
      `CHK(hc, rows[k].h);
      `CHK(got, rows[k].tx & (16'hffff >> (16 - nbits)));
      `CHK(o_rx_data, rows[k].rep & (16'hffff >> (16 - nbits)));
      pop();
    end
    // fill while disabled: ninth word refused, then all eight go out in order
    @(posedge i_clk_sys);
    {i_enable, i_frame_fmt, i_size, i_clk_pha, i_prescale} <= {1'b0, 2'h0, 4'hf, 1'b0, 8'h02};
    reply <= 16'h1234;
    for (int k = 0; k < 9; k++) push(16'h0100 + 16'(k));
    @(negedge i_clk_sys);
    `CHK({o_tx_not_full, o_busy}, 2'h1);
    @(posedge i_clk_sys);
    i_enable <= 1'b1;
    @(negedge i_clk_sys);
    wait_idle();
    `CHK({o_rx_full, got}, {1'b1, 16'h0107});
    for (int k = 0; k < 8; k++) begin
      @(negedge i_clk_sys);
      `CHK(o_rx_data, 16'h1234);
      pop();
    end
    @(negedge i_clk_sys);
    `CHK(o_rx_not_empty, 1'b0);
    // slave mode, output driven then released
    @(posedge i_clk_sys);
    {i_master, i_size} <= {1'b0, 4'h7};
    push(16'h00a5);
    sframe(8'h3c);
    `CHK(sgot, 8'ha5);
    @(posedge i_clk_sys);
    i_slave_out_off <= 1'b1;
    sframe(8'hc6);
    // reset while disabled with two words waiting empties the buffers
    @(posedge i_clk_sys);
    {i_enable, i_slave_out_off, i_master} <= 3'h1;
    push(16'h0011);
    push(16'h0022);
    @(posedge i_clk_sys);
    i_rst <= 1'b1;
    @(negedge i_clk_sys);
    `CHK({o_tx_empty, o_busy, o_sclk_oe}, 3'h4);
    @(posedge i_clk_sys);
    i_rst <= 1'b0;
    // port works again after the reset with words waiting
    @(posedge i_clk_sys);
    i_enable <= 1'b1;
    xfer(16'h005a);
    `CHK(hc, 8'h04);
    `CHK(got, 16'h005a);
    `CHK(o_rx_data, 16'h0034);
    end_sim();
  end

  // watchdog
  initial begin
    repeat (40000) @(posedge i_clk_sys);
    fails++;
    end_sim();
  end
endmodule // tb_sync_serial_port
